// ==== design/bank_decode_pkg.sv ====
// Purpose: Shared constants for the program counter and banked data memory decode.
// Assumes: Data file addresses are 7-bit offsets within a bank of 128 bytes.
// Notes:   Offsets are byte offsets within a bank, mirrored where the decode says so.
package bank_decode_pkg;
  // ***********************************************************************
  // Data memory layout
  // ***********************************************************************
  localparam logic [6:0] OFS_INDIRECT  = 7'h00;
  localparam logic [6:0] OFS_PCL       = 7'h02;
  localparam logic [6:0] OFS_STATUS    = 7'h03;
  localparam logic [6:0] OFS_POINTER   = 7'h04;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_HIGH_LATCH    = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL    = 7'h0b;
  localparam logic [6:0] OFS_PFLAG1    = 7'h0c;
  localparam logic [6:0] OFS_GPR_BASE  = 7'h20;
  localparam logic [6:0] OFS_ALIAS_LIM = 7'h40;
  localparam logic [1:0] BANK_ONE      = 2'h1;
  localparam logic [1:0] RAM_HI_TAG    = 2'h3;
  localparam int         RAM_BYTES     = 128;
  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  localparam int STATUS_IRP_BIT  = 7;
  localparam int STATUS_SEL_HI   = 6;
  localparam int STATUS_SEL_LO   = 5;
  localparam int INTERRUPT_CONTROL_GIE_BIT  = 7;
  localparam logic [7:0] PFLAG1_IMPL_MASK = 8'h4f;
  // Peripheral event inputs: 4 converter, 3 serial, 2 capture, 1 timer2, 0 timer1.
  localparam int PFLAG1_EVENTS   = 5;
  // ***********************************************************************
  // Reset values and vectors
  // ***********************************************************************
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [7:0]  STATUS_RST   = 8'h18;
  localparam logic [7:0]  POINTER_RST  = 8'h00;
  localparam logic [7:0]  PROGRAM_COUNTER_HIGH_LATCH_RST   = 8'h00;
  localparam logic [7:0]  INTERRUPT_CONTROL_RST   = 8'h00;
  localparam logic [7:0]  PFLAG1_RST   = 8'h00;
endpackage

// ==== design/gpr_ram.sv ====
// Purpose: General purpose register storage with a registered read port.
// Assumes: One access per cycle; read and write never target it together.
// Notes:   Contents are not cleared by reset.
`timescale 1ns/10ps
`default_nettype none
module gpr_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  input  wire logic                     clk_sys, // System clock.
  input  wire logic                     rst,     // Synchronous reset, high.
  input  wire logic                     wr_en,   // Write strobe.
  input  wire logic                     rd_en,   // Read strobe.
  input  wire logic [$clog2(DEPTH)-1:0] addr,    // Word index.
  input  wire logic [WIDTH-1:0]         wdata,   // Write data.
  output logic      [WIDTH-1:0]         rdata_q  // Registered read data.
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Store on write and capture the addressed word on read.
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
    if (rst)
    begin
      rdata_q <= '0;
    end
    else if (rd_en)
    begin
      rdata_q <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// ==== design/mem_bank_decode.sv ====
// Purpose: Program counter addressing and banked data memory decode for an 8-bit core.
// Assumes: The core drives one data request per cycle and program control strobes.
// Notes:   Data reads answer two cycles after the request; writes take effect at once.
// Overview of operation
// [RQ1] Separate program and data buses, same cycle.
// [RQ2] Data EEPROM reached via pointer, not mapped.
// [RQ3] Thirteen bit program counter, 8K word space.
// [RQ4] Fetch address wraps above implemented flash.
// [RQ5] Reset loads 0000h; interrupt vectors 0004h.
// [RQ6] Status bits 6:5 select one of four banks.
// [RQ7] Bank holds 128 bytes: registers low, RAM high.
// [RQ8] Core registers mirrored into every bank.
// [RQ9] Direct and pointer based indirect data access.
// [RQ10] Flags set regardless of any enable bit.
// [RQ11] Software clears flags before enabling interrupts.
// [RQ12] Offset 0 indirect; upper bank RAM aliases bank 0.
// [RQ13] Flag register at 0Ch, software cleared only.
`timescale 1ns/10ps
`default_nettype none
module mem_bank_decode
  import bank_decode_pkg::*;
#(
  parameter int PROG_WORDS = 2048,
  parameter int EE_BYTES   = 256
) (
  input  wire logic                     clk_sys,       // System clock, 125 MHz.
  input  wire logic                     rst,           // Synchronous reset, high.
  input  wire logic                     pc_step,       // Advance program counter.
  input  wire logic                     pc_jump,       // Load counter from jump target.
  input  wire logic [10:0]              jump_addr,     // Jump target low bits.
  input  wire logic                     irq_take,      // Interrupt accepted by the core.
  input  wire logic                     data_rd,       // Data read request.
  input  wire logic                     data_wr,       // Data write request.
  input  wire logic [6:0]               data_addr,     // Direct file offset.
  input  wire logic [7:0]               data_wdata,    // Data write value.
  input  wire logic [PFLAG1_EVENTS-1:0] periph_event,  // Peripheral condition pulses.
  output logic      [12:0]              prog_addr_q,   // Wrapped program fetch address.
  output logic      [12:0]              pc_q,          // Full program counter.
  output logic      [7:0]               data_rdata_q,  // Data read value.
  output logic                          data_rvalid_q, // Read data valid pulse.
  output logic      [1:0]               bank_q,        // Selected data bank.
  output logic                          global_irq_enable_q, // Global enable level.
  output logic      [7:0]               flags_q,       // Peripheral flag bits.
  output logic      [7:0]               ee_addr_q      // Data EEPROM address.
);
  // ***********************************************************************
  // Elaboration checks
  // ***********************************************************************
  if (!(PROG_WORDS == 1024 || PROG_WORDS == 2048))
  begin : g_bad_prog
    $error("PROG_WORDS must be 1024 or 2048");
  end
  if (!(EE_BYTES == 128 || EE_BYTES == 256))
  begin : g_bad_ee
    $error("EE_BYTES must be 128 or 256");
  end

  localparam logic [12:0] PROG_MASK = 13'(PROG_WORDS - 1);
  localparam logic [7:0]  EE_MASK   = 8'(EE_BYTES - 1);

  // ***********************************************************************
  // State
  // ***********************************************************************
  typedef struct packed {
    logic [12:0] pc;
    logic [12:0] prog_addr;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [7:0]  program_counter_high_latch;
    logic [7:0]  interrupt_control;
    logic [7:0]  pflag1;
    logic        rd1_valid;
    logic        rd1_ram;
    logic [7:0]  rd1_sfr;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  ee_addr;
  } state_t;

  state_t      st_q;
  state_t      st_d;
  logic [8:0]  full_addr;
  logic [6:0]  ofs;
  logic [1:0]  bank;
  logic        is_ram;
  logic [6:0]  ram_idx;
  logic [7:0]  ram_rdata;
  logic [7:0]  sfr_val;
  logic [7:0]  flag_set;

  // Resolve the effective address: offset 0 takes it from the pointer.
  always_comb
  begin
    if (data_addr == OFS_INDIRECT) // see [RQ9] see [RQ12]
    begin
      full_addr = {st_q.status[STATUS_IRP_BIT], st_q.pointer};
    end
    else
    begin
      full_addr = {st_q.status[STATUS_SEL_HI:STATUS_SEL_LO], data_addr}; // see [RQ6]
    end
    ofs     = full_addr[6:0];
    bank    = full_addr[8:7];
    is_ram  = (ofs >= OFS_GPR_BASE); // see [RQ7]
    // Bank 1 keeps 32 private bytes; all other RAM windows alias bank 0.
    if (bank == BANK_ONE && ofs < OFS_ALIAS_LIM)
    begin
      ram_idx = {RAM_HI_TAG, ofs[4:0]};
    end
    else
    begin
      ram_idx = 7'(ofs - OFS_GPR_BASE); // see [RQ12]
    end
  end

  // Register read mux; core registers answer in every bank.
  always_comb
  begin
    sfr_val = 8'h00;
    unique case (ofs) // see [RQ8]
      OFS_PCL:     sfr_val = st_q.pc[7:0];
      OFS_STATUS:  sfr_val = st_q.status;
      OFS_POINTER: sfr_val = st_q.pointer;
      OFS_PROGRAM_COUNTER_HIGH_LATCH:  sfr_val = st_q.program_counter_high_latch;
      OFS_INTERRUPT_CONTROL:  sfr_val = st_q.interrupt_control;
      OFS_PFLAG1:  sfr_val = (bank == 2'h0) ? (st_q.pflag1 & PFLAG1_IMPL_MASK) : 8'h00;
      default:     sfr_val = 8'h00;
    endcase
  end

  // Map event inputs onto their flag bit positions.
  assign flag_set = {1'b0, periph_event[4], 2'b00, periph_event[3:0]};

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb
  begin
    st_d = st_q;
    // Program counter: interrupt, jump, counter write, then step.
    if (irq_take)
    begin
      st_d.pc = IRQ_VECTOR; // see [RQ5]
    end
    else if (pc_jump)
    begin
      st_d.pc = {st_q.program_counter_high_latch[4:3], jump_addr}; // see [RQ3]
    end
    else if (data_wr && !is_ram && ofs == OFS_PCL)
    begin
      st_d.pc = {st_q.program_counter_high_latch[4:0], data_wdata};
    end
    else if (pc_step)
    begin
      st_d.pc = 13'(st_q.pc + 13'h0001);
    end
    // Fetch bus runs every cycle regardless of data traffic.
    st_d.prog_addr = st_d.pc & PROG_MASK; // see [RQ1] see [RQ4]
    // Register writes through the same decode as reads.
    if (data_wr && !is_ram)
    begin
      unique case (ofs) // see [RQ8]
        OFS_STATUS:  st_d.status  = data_wdata;
        OFS_POINTER: st_d.pointer = data_wdata;
        OFS_PROGRAM_COUNTER_HIGH_LATCH:  st_d.program_counter_high_latch  = data_wdata;
        OFS_INTERRUPT_CONTROL:  st_d.interrupt_control  = data_wdata;
        OFS_PFLAG1:
        begin
          if (bank == 2'h0)
          begin
            st_d.pflag1 = data_wdata & PFLAG1_IMPL_MASK; // see [RQ13]
          end
        end
        default:     st_d.pflag1 = st_d.pflag1;
      endcase
    end
    // Events set flags whatever the enables say, and win over a clear.
    st_d.pflag1  = (st_d.pflag1 | flag_set) & PFLAG1_IMPL_MASK; // see [RQ10] see [RQ13]
    st_d.ee_addr = st_d.pointer & EE_MASK; // see [RQ2]
    // Two-stage read return.
    st_d.rd1_valid = data_rd;
    st_d.rd1_ram   = is_ram;
    st_d.rd1_sfr   = sfr_val;
    st_d.rvalid    = st_q.rd1_valid;
    if (st_q.rd1_valid)
    begin
      st_d.rdata = st_q.rd1_ram ? ram_rdata : st_q.rd1_sfr;
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q           <= '0;
      st_q.pc        <= RESET_VECTOR; // see [RQ5]
      st_q.prog_addr <= RESET_VECTOR;
      st_q.status    <= STATUS_RST;
      st_q.pointer   <= POINTER_RST;
      st_q.program_counter_high_latch    <= PROGRAM_COUNTER_HIGH_LATCH_RST;
      st_q.interrupt_control    <= INTERRUPT_CONTROL_RST;
      st_q.pflag1    <= PFLAG1_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // General purpose RAM behind the decode.
  gpr_ram #(
    .WIDTH (8),
    .DEPTH (RAM_BYTES)
  ) u_gpr_ram (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr_en   (data_wr && is_ram),
    .rd_en   (data_rd && is_ram),
    .addr    (ram_idx),
    .wdata   (data_wdata),
    .rdata_q (ram_rdata)
  );

  // Outputs straight from state flops.
  assign prog_addr_q         = st_q.prog_addr;
  assign pc_q                = st_q.pc;
  assign data_rdata_q        = st_q.rdata;
  assign data_rvalid_q       = st_q.rvalid;
  assign bank_q              = st_q.status[STATUS_SEL_HI:STATUS_SEL_LO];
  assign global_irq_enable_q = st_q.interrupt_control[INTERRUPT_CONTROL_GIE_BIT];
  assign flags_q             = st_q.pflag1;
  assign ee_addr_q           = st_q.ee_addr;
endmodule
`default_nettype wire

// ==== verification/core_model.sv ====
// Purpose: Core side model issuing program control and data requests.
// Assumes: Requests start 1 ns after a rising edge and last one edge.
// Notes:   The testbench calls these tasks by hierarchical name.
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic       clk_sys,       // System clock.
  input  wire logic [7:0] data_rdata_q,  // Read value.
  input  wire logic       data_rvalid_q, // Read valid pulse.
  output var  logic       pc_step,       // Advance request.
  output var  logic       pc_jump,       // Jump request.
  output var  logic [10:0] jump_addr,    // Jump target.
  output var  logic       irq_take,      // Interrupt accepted.
  output var  logic       data_rd,       // Read request.
  output var  logic       data_wr,       // Write request.
  output var  logic [6:0] data_addr,     // File offset.
  output var  logic [7:0] data_wdata,    // Write value.
  output var  logic [4:0] periph_event   // Peripheral pulses.
);
  // *****
  // Requests
  // *****
  // Everything idles so nothing is requested during reset.
  initial
  begin
    {pc_step, pc_jump, irq_take, data_rd, data_wr} = 5'h00;
    {jump_addr, data_addr, data_wdata, periph_event} = 31'h0;
  end
  // One program control request, taken at the next edge.
  task automatic ctl(input logic s, j, i, input logic [10:0] a);
    {pc_step, pc_jump, irq_take} = {s, j, i};
    jump_addr = a;
    @(posedge clk_sys);
    #1 {pc_step, pc_jump, irq_take} = 3'h0;
    // Let an edge pass so that a following request is raised in a later time step.
    @(posedge clk_sys);
    #1;
  endtask
  // Released write data shows the inverse, never the old byte.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    data_wr = 1'b1;
    data_addr = a;
    data_wdata = d;
    @(posedge clk_sys);
    #1 data_wr = 1'b0;
    data_wdata = ~d;
    // Idle edge keeps two writes from toggling the strobe in one time step.
    @(posedge clk_sys);
    #1;
  endtask
  // A read waits a bounded time for the valid pulse.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    data_rd = 1'b1;
    data_addr = a;
    @(posedge clk_sys);
    #1 data_rd = 1'b0;
    for (int n = 0; n < 4 && data_rvalid_q !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    d = data_rvalid_q === 1'b1 ? data_rdata_q : 8'hxx;
  endtask
  // A one cycle burst of peripheral conditions.
  task automatic ev(input logic [4:0] e);
    periph_event = e;
    @(posedge clk_sys);
    #1 periph_event = 5'h00;
    @(posedge clk_sys);
    #1;
  endtask
  // With bank 0 selected, stale flags are cleared before the global enable is set.
  task automatic irq_on();
    wr(7'h0c, 8'h00);
    wr(7'h0b, 8'h80);
  endtask
endmodule
`default_nettype wire

// ==== verification/mem_bank_decode_properties.sv ====
// Purpose: Port level checks of the memory decode block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound into every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module mem_bank_decode_properties
  import bank_decode_pkg::*;
#(
  parameter int PROG_WORDS = 2048,
  parameter int EE_BYTES   = 256
) (
  input wire logic clk_sys, rst, pc_step, pc_jump, irq_take, data_rd, data_wr, // Controls.
  input wire logic [10:0] jump_addr,      // Jump target.
  input wire logic [6:0]  data_addr,      // Offset.
  input wire logic [7:0]  data_wdata,     // Write value.
  input wire logic [4:0]  periph_event,   // Pulses.
  input wire logic [12:0] prog_addr_q, pc_q, // Counters.
  input wire logic [7:0]  data_rdata_q, flags_q, ee_addr_q, // Values.
  input wire logic data_rvalid_q, global_irq_enable_q, // Levels.
  input wire logic [1:0]  bank_q          // Bank.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // *****
  // Checks
  // *****
  // Event pulses mapped onto their flag bit positions.
  logic [7:0] ev_map;
  assign ev_map = {1'b0, periph_event[4], 2'b00, periph_event[3:0]};
  sequence read_taken; data_rd; endsequence
  sequence answer_two; ##2 data_rvalid_q; endsequence
  a_read_latency: assert property (read_taken |-> answer_two)
    else $error("read answer missing");
  a_answer_cause: assert property (data_rvalid_q |-> $past(data_rd, 2))
    else $error("read answer without request");
  a_reset_vector: assert property ($fell(rst) |-> pc_q == RESET_VECTOR)
    else $error("counter not at reset vector");
  a_irq_vector: assert property (irq_take |=> pc_q == IRQ_VECTOR && prog_addr_q == IRQ_VECTOR)
    else $error("interrupt vector wrong");
  a_fetch_wrap: assert property (prog_addr_q == (pc_q & 13'(PROG_WORDS - 1)))
    else $error("fetch address not wrapped");
  a_pc_step: assert property (pc_step && !pc_jump && !irq_take && !data_wr |=> pc_q == $past(pc_q) + 13'h1)
    else $error("counter did not advance");
  a_jump_low: assert property (pc_jump && !irq_take |=> pc_q[10:0] == $past(jump_addr))
    else $error("jump target not loaded");
  a_flag_set: assert property ((|periph_event) |=> (flags_q & $past(ev_map)) == $past(ev_map))
    else $error("flag not set by event");
  a_flag_mask: assert property ((flags_q & ~PFLAG1_IMPL_MASK) == 8'h00)
    else $error("unimplemented flag bit set");
  a_bank_hold: assert property (!data_wr |=> $stable(bank_q))
    else $error("bank changed without write");
  a_ee_range: assert property (ee_addr_q < EE_BYTES)
    else $error("eeprom address out of range");
endmodule
bind mem_bank_decode mem_bank_decode_properties #(.PROG_WORDS(PROG_WORDS), .EE_BYTES(EE_BYTES)) u_props (
  .clk_sys(clk_sys), .rst(rst), .pc_step(pc_step), .pc_jump(pc_jump), .irq_take(irq_take),
  .data_rd(data_rd), .data_wr(data_wr), .jump_addr(jump_addr), .data_addr(data_addr),
  .data_wdata(data_wdata), .periph_event(periph_event), .prog_addr_q(prog_addr_q), .pc_q(pc_q),
  .data_rdata_q(data_rdata_q), .flags_q(flags_q), .ee_addr_q(ee_addr_q), .data_rvalid_q(data_rvalid_q),
  .global_irq_enable_q(global_irq_enable_q), .bank_q(bank_q));
`default_nettype wire

// ==== verification/tb_mem_bank_decode.sv ====
// Purpose: Self-checking bench for the memory decode block.
// Assumes: Small variant, 1K words and 128 eeprom bytes.
// Notes:   Expected values come from the memory map alone.
`timescale 1ns/10ps
`default_nettype none
module tb_mem_bank_decode
  import bank_decode_pkg::*;
;
  logic clk_sys, rst, pc_step, pc_jump, irq_take, data_rd, data_wr, data_rvalid_q, global_irq_enable_q;
  logic [10:0] jump_addr;
  logic [6:0]  data_addr;
  logic [7:0]  data_wdata, data_rdata_q, flags_q, ee_addr_q, d;
  logic [4:0]  periph_event;
  logic [12:0] prog_addr_q, pc_q;
  logic [1:0]  bank_q;
  int          err_total, comparisons;
  mem_bank_decode #(.PROG_WORDS(1024), .EE_BYTES(128)) uut (.clk_sys(clk_sys), .rst(rst),
    .pc_step(pc_step), .pc_jump(pc_jump), .jump_addr(jump_addr), .irq_take(irq_take),
    .data_rd(data_rd), .data_wr(data_wr), .data_addr(data_addr), .data_wdata(data_wdata),
    .periph_event(periph_event), .prog_addr_q(prog_addr_q), .pc_q(pc_q), .data_rdata_q(data_rdata_q),
    .data_rvalid_q(data_rvalid_q), .bank_q(bank_q), .global_irq_enable_q(global_irq_enable_q),
    .flags_q(flags_q), .ee_addr_q(ee_addr_q));
  core_model core (.clk_sys(clk_sys), .data_rdata_q(data_rdata_q), .data_rvalid_q(data_rvalid_q),
    .pc_step(pc_step), .pc_jump(pc_jump), .jump_addr(jump_addr), .irq_take(irq_take),
    .data_rd(data_rd), .data_wr(data_wr), .data_addr(data_addr), .data_wdata(data_wdata),
    .periph_event(periph_event));
  // *****
  // Checking
  // *****
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [12:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Reset state of counter, bank and status.
  task automatic t_reset();
    chk(pc_q, RESET_VECTOR);
    chk(13'(bank_q), 13'h0);
    core.rd(OFS_STATUS, d);
    chk(13'(d), 13'(STATUS_RST));
  endtask
  // Jump above the implemented words wraps; step and interrupt vector.
  task automatic t_prog();
    core.wr(OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h08);
    core.ctl(1'b0, 1'b1, 1'b0, 11'h420);
    chk(pc_q, 13'h0c20);
    chk(prog_addr_q, 13'h0020);
    core.ctl(1'b1, 1'b0, 1'b0, 11'h0);
    chk(pc_q, 13'h0c21);
    // A counter step and a data write share one edge on their own buses.
    fork
      core.ctl(1'b1, 1'b0, 1'b0, 11'h0);
      core.wr(7'h21, 8'h69);
    join
    chk(pc_q, 13'h0c22);
    core.rd(7'h21, d);
    chk(13'(d), 13'h069);
    core.ctl(1'b0, 1'b0, 1'b1, 11'h0);
    chk(pc_q, IRQ_VECTOR);
  endtask
  // Every bank: select, mirrored status, RAM aliasing.
  task automatic t_bank();
    core.wr(OFS_STATUS, 8'h18);
    core.wr(7'h20, 8'h5a);
    core.wr(OFS_STATUS, 8'h38);
    core.wr(7'h20, 8'ha5);
    // The last offset below the RAM window is a register slot, not storage.
    core.wr(7'h1f, 8'hee);
    core.rd(7'h1f, d);
    chk(13'(d), 13'h000);
    for (int b = 0; b < 4; b++)
    begin
      core.wr(OFS_STATUS, {1'b0, 2'(b), 5'h18});
      chk(13'(bank_q), 13'(b));
      core.rd(OFS_STATUS, d);
      chk(13'(d), 13'({1'b0, 2'(b), 5'h18}));
      core.rd(7'h20, d);
      chk(13'(d), b == 1 ? 13'h0a5 : 13'h05a);
    end
  endtask
  // Indirect write lands in bank 1 private RAM; eeprom address follows.
  task automatic t_indir();
    core.wr(OFS_STATUS, 8'h18);
    core.wr(OFS_POINTER, 8'ha7);
    core.wr(OFS_INDIRECT, 8'h3c);
    core.rd(OFS_INDIRECT, d);
    chk(13'(d), 13'h03c);
    chk(13'(ee_addr_q), 13'h027);
    core.wr(OFS_STATUS, 8'h38);
    core.rd(7'h27, d);
    chk(13'(d), 13'h03c);
  endtask
  // Flags set with the enable off and on; software load is masked.
  task automatic t_flags();
    core.wr(OFS_STATUS, 8'h18);
    core.ev(5'h11);
    chk(13'(flags_q), 13'h041);
    core.irq_on();
    chk(13'(global_irq_enable_q), 13'h1);
    core.ev(5'h0e);
    chk(13'(flags_q), 13'h00e);
    core.wr(OFS_PFLAG1, 8'hff);
    chk(13'(flags_q), 13'h04f);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog well beyond the fewer than a hundred cycles the tests need.
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_reset();
    t_prog();
    t_bank();
    t_indir();
    t_flags();
    give_verdict();
  end
endmodule
`default_nettype wire
